// *** sim/apf_framer_checker.sv ***
`timescale 1ns/10ps
`default_nettype none

module apf_framer_checker (
   // clock and reset
   input  wire logic        clk_sys,
   input  wire logic        rst_b,
   // register port
   input  wire logic        reg_rd,
   input  wire logic [31:0] reg_rdata,
   // requests
   input  wire logic        ts_valid,
   input  wire logic        ts_ready,
   input  wire logic        rx_ready,
   // frame bytes
   input  wire logic        out_valid,
   input  wire logic [7:0]  out_data,
   input  wire logic        out_ready
);
   // ********
   // byte position in the outgoing frame
   // ********
   logic [8:0]  pos;
   logic [15:0] len;
   logic [7:0]  sum;
   logic [7:0]  typ;

   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!rst_b);

   always_ff @(posedge clk_sys) begin
      if (!rst_b) begin
         pos <= 9'h0;
         len <= 16'h0;
         sum <= 8'h0;
         typ <= 8'h0;
      end else if (out_valid && out_ready) begin
         pos <= (pos > 9'h2 && {7'h0, pos} == len + 16'h3) ? 9'h0 : pos + 9'h1;
         if (pos == 9'h1) len[15:8] <= out_data;
         if (pos == 9'h2) len[7:0] <= out_data;
         if (pos == 9'h3) typ <= out_data;
         sum <= (pos < 9'h3) ? 8'h0 : sum + out_data;
      end
   end

   a_delim_first: assert property (out_valid && pos == 9'h0 |-> out_data == 8'h7e)
      else $error("delimiter missing");
   a_type_known: assert property (out_valid && pos == 9'h3 |-> out_data == 8'h90 || out_data == 8'h8b)
      else $error("unknown frame type");
   a_status_len: assert property (out_valid && pos == 9'h3 && out_data == 8'h8b |-> len == 16'h7)
      else $error("status length wrong");
   a_rx_len: assert property (out_valid && pos == 9'h3 && out_data == 8'h90 |-> len >= 16'hc && len <= 16'h10b)
      else $error("rx length out of range");
   a_csum_match: assert property (out_valid && pos > 9'h3 && {7'h0, pos} == len + 16'h3 |-> out_data == 8'hff - sum)
      else $error("checksum wrong");
   a_opt_reserved: assert property (out_valid && typ == 8'h90 && pos == 9'he |-> !out_data[3])
      else $error("reserved option bit set");
   a_status_code: assert property (out_valid && typ == 8'h8b && pos == 9'h8 |->
      out_data inside {8'h00, 8'h01, 8'h02, 8'h03, 8'h21, 8'h31, 8'h34, 8'h35, 8'h74})
      else $error("unlisted delivery status");
   a_out_hold: assert property (out_valid && !out_ready |=> out_valid && $stable(out_data))
      else $error("byte lost under stall");
   a_ready_drop: assert property (ts_valid && ts_ready |=> !ts_ready && !rx_ready)
      else $error("request taken mid frame");
   a_ts_first: assert property (ts_valid && ts_ready && !out_valid |-> ##2 out_valid && out_data == 8'h7e)
      else $error("status frame late");
   a_rd_idle: assert property (!reg_rd |=> reg_rdata == 32'h0)
      else $error("read data not cleared");
endmodule : apf_framer_checker

bind apf_framer apf_framer_checker chk_u (.*);

`default_nettype wire

// *** sim/apf_host_model.sv ***
`timescale 1ns/10ps
`default_nettype none

module apf_host_model (
   // clock and reset
   input  wire logic       clk_sys,
   input  wire logic       rst_b,
   // frame bytes
   input  wire logic       out_valid,
   input  wire logic [7:0] out_data,
   output logic            out_ready
);
   // ********
   // byte sink and frame parser
   // ********
   int seed = 67625;
   bit stall = 1'b0;
   int bad = 0;
   int sum;
   int frm[$];
   int got[$];

   // random stalls work the output buffer
   always @(posedge clk_sys) begin
      out_ready <= rst_b && !stall && ($random(seed) % 4 != 0);
      if (rst_b && out_valid && out_ready) begin
         if (frm.size() > 0 || out_data == 8'h7e) frm.push_back(out_data); // raw bytes, hunt delimiter
         if (frm.size() > 3 && frm.size() == frm[1] * 256 + frm[2] + 4) begin
            sum = 0;
            foreach (frm[i]) if (i > 2) sum += frm[i];
            if (sum % 256 == 255) got = {got, frm};
            else bad++;
            frm = {};
         end
      end
   end
endmodule : apf_host_model

`default_nettype wire

// *** sim/testbench.sv ***
`timescale 1ns/10ps
`default_nettype none
`include "apf_map.svh"

module testbench;
   import apf_pkg::*;
   // ********
   // stimulus, model and checks
   // ********
   logic             clk_sys, rst_b, reg_wr, reg_rd, rx_valid, pl_valid, ts_valid;
   logic             rx_ready, pl_ready, ts_ready, out_valid, out_ready;
   logic [7:0]       reg_addr, pl_data, ts_frame_id, ts_retries, ts_discovery, out_data, rx_len, opt;
   logic [31:0]      reg_wdata, reg_rdata;
   logic [63:0]      rx_src_long;
   logic [15:0]      rx_src_short, ts_dest_short;
   apf_delivery_type ts_kind;
   int               seed = 67625;
   int               mismatches = 0;
   int               compares = 0;
   int               n_rx = 0;
   int               n_ts = 0;
   int               exp_q[$];
   int               codes[9] = '{8'h00, 8'h01, 8'h02, 8'h03, 8'h21, 8'h31, 8'h34, 8'h35, 8'h74};

   apf_framer dut_u (.*, .rx_opt_ack(opt[0]), .rx_opt_bcast(opt[1]), .rx_opt_allpan(opt[2]),
      .rx_opt_secure(opt[4]), .rx_opt_apsenc(opt[5]), .rx_opt_method(opt[7:6]));
   apf_host_model host_u (.clk_sys(clk_sys), .rst_b(rst_b), .out_valid(out_valid), .out_data(out_data),
      .out_ready(out_ready));

   initial begin
      clk_sys = 1'b0;
      forever #5 clk_sys = ~clk_sys;
   end

   task automatic conclude;
      $display("counts: compares %0d mismatches %0d", compares, mismatches);
      if (mismatches == 0 && compares > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask : conclude

   task automatic chk(input string what, input logic [31:0] e, g);
      compares++;
      if (g !== e) begin
         mismatches++;
         $display("MISMATCH %s expected %h seen %h", what, e, g);
      end
   endtask : chk

   // ready is a flop: its falling-edge value is what the next rising edge takes
   task automatic hs(input int w);
      int n = 0;
      do begin
         @(negedge clk_sys);
         n++;
         if (n > 4000) begin
            mismatches++;
            conclude();
         end
      end while ((w == 0 ? rx_ready : w == 1 ? ts_ready : pl_ready) !== 1'b1);
      @(posedge clk_sys);
   endtask : hs

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      reg_addr  <= a;
      reg_wdata <= d;
      reg_wr    <= 1'b1;
      @(posedge clk_sys);
      reg_wr <= 1'b0;
   endtask : wr

   task automatic rd(input logic [7:0] a, input logic [31:0] e);
      reg_addr <= a;
      reg_rd   <= 1'b1;
      @(posedge clk_sys);
      reg_rd <= 1'b0;
      @(negedge clk_sys);
      chk("register", e, reg_rdata);
      @(posedge clk_sys);
   endtask : rd

   task automatic frame(input int b[$]);
      int s = 0;
      exp_q.push_back(8'h7e);
      exp_q.push_back(b.size() >> 8);
      exp_q.push_back(b.size() & 255);
      foreach (b[i]) begin
         exp_q.push_back(b[i]);
         s += b[i];
      end
      exp_q.push_back(255 - s % 256);
   endtask : frame

   task automatic drain(input string what);
      int n = 0;
      while (host_u.got.size() < exp_q.size()) begin
         @(posedge clk_sys);
         n++;
         if (n > 9000) begin
            mismatches++;
            conclude();
         end
      end
      while (exp_q.size() > 0) chk(what, exp_q.pop_front(), host_u.got.pop_front());
      $display("done: %s", what);
   endtask : drain

   task automatic send_ts(input int k);
      logic [7:0]  id, rt, dc;
      logic [15:0] ad;
      id = (k == 0) ? 8'h7e : 8'($random(seed));
      rt = 8'($random(seed));
      dc = 8'($random(seed));
      ad = k ? 16'($random(seed)) : 16'hfffe;
      ts_frame_id   <= id;
      ts_dest_short <= ad;
      ts_retries    <= rt;
      ts_discovery  <= dc;
      ts_kind       <= apf_delivery_type'(k);
      ts_valid      <= 1'b1;
      hs(1);
      frame('{8'h8b, id, ad[15:8], ad[7:0], rt, codes[k], dc});
      n_ts++;
   endtask : send_ts

   task automatic send_rx(input int m, input int n, input bit keep);
      logic [63:0] sl;
      logic [15:0] ss;
      logic [7:0]  o;
      int          b[$];
      @(posedge clk_sys);
      sl = {$random(seed), $random(seed)};
      ss = 16'($random(seed));
      o  = {2'(m), 6'($random(seed))};
      b  = {8'h90};
      for (int i = 7; i >= 0; i--) b.push_back(sl[8*i +: 8]);
      b.push_back(ss[15:8]);
      b.push_back(ss[7:0]);
      b.push_back(o & 8'hf7);
      for (int i = 0; i < n; i++) b.push_back($random(seed) & 255);
      rx_src_long  <= sl;
      rx_src_short <= ss;
      opt          <= o;
      rx_len       <= 8'(n);
      rx_valid     <= 1'b1;
      hs(0);
      rx_valid <= 1'b0;
      if (keep) begin
         for (int i = 12; i < b.size(); i++) begin
            pl_data  <= 8'(b[i]);
            pl_valid <= 1'b1;
            hs(2);
         end
         pl_valid <= 1'b0;
         frame(b);
         n_rx++;
      end
   endtask : send_rx

   initial begin
      {rst_b, reg_wr, reg_rd, rx_valid, pl_valid, ts_valid, reg_addr, pl_data, rx_len, opt} = '0;
      {ts_frame_id, ts_retries, ts_discovery, reg_wdata, rx_src_long, rx_src_short, ts_dest_short} = '0;
      ts_kind = APF_ST_SUCCESS;
      repeat (3) @(posedge clk_sys);
      rst_b <= 1'b1;
      @(posedge clk_sys);
      rd(`APF_REG_CTRL, 32'h0001_0100);
      rd(`APF_REG_ID, `APF_ID_VALUE);
      wr(`APF_REG_ID, 32'h0);
      rd(`APF_REG_ID, `APF_ID_VALUE);
      rd(8'h20, 32'h0);
      $display("done: registers");
      for (int k = 0; k < 9; k++) send_ts(k);
      ts_valid <= 1'b0;
      drain("status frames");
      host_u.stall = 1'b1;
      send_ts(8);
      ts_valid <= 1'b0;
      repeat (20) @(posedge clk_sys);
      chk("stalled valid", 1, out_valid);
      chk("stalled ready", 0, ts_ready);
      host_u.stall = 1'b0;
      drain("stalled frame");
      for (int m = 0; m < 4; m++) send_rx(m, m == 3 ? 255 : m * 3, 1'b1);
      drain("received frames");
      wr(`APF_REG_CTRL, 32'h0001_0101);
      send_rx(1, 3, 1'b0);
      repeat (20) @(posedge clk_sys);
      chk("dropped frame bytes", 0, host_u.got.size() + host_u.frm.size());
      rd(`APF_REG_DROP_COUNT, 32'h1);
      wr(`APF_REG_CTRL, 32'h0001_0100);
      rd(`APF_REG_RX_COUNT, 32'(n_rx));
      rd(`APF_REG_TS_COUNT, 32'(n_ts));
      chk("bad checksums", 0, host_u.bad);
      $display("done: counters");
      conclude();
   end
endmodule : testbench

`default_nettype wire

// *** verilog/apf_framer.sv ***
`timescale 1ns/10ps
`default_nettype none
`include "apf_map.svh"

// Notes on behaviour
// - status codes 0x00 success, 0x01 ack fail, 0x02 channel fail, 0x03 unrequested
// - status codes 0x21, 0x31, 0x34, 0x35, 0x74 for the later failure kinds
// - status frame type 0x8B carries the frame id the host supplied
// - status frame carries the discovered 16-bit destination address
// - with output format 0 a received packet gives a 0x90 frame
// - every frame opens with delimiter 7E
// - 16-bit length counts bytes between length field and checksum
// - received frame holds 64-bit sender address, then 16-bit sender address
// - option bits: ack, broadcast, all pans, reserved, secure, encrypted
// - option bits 7:6 hold the mesh delivery method
// - option bits combine freely; each set independently
// - payload bytes follow the options byte up to the checksum
// - checksum is 0xFF minus low byte of sum from offset 3
// - with escaping mode 1 bytes leave unescaped, no stuffing
// - status frame: id, address, retries, delivery, discovery at offsets 4..9
module apf_framer
   import apf_pkg::*;
(
   // clock and reset
   input  wire logic                       clk_sys,
   input  wire logic                       rst_b,
   // register port
   input  wire logic [7:0]                 reg_addr,
   input  wire logic [31:0]                reg_wdata,
   input  wire logic                       reg_wr,
   input  wire logic                       reg_rd,
   output logic      [31:0]                reg_rdata,
   // received packet request
   input  wire logic                       rx_valid,
   output logic                            rx_ready,
   input  wire logic [63:0]                rx_src_long,
   input  wire logic [15:0]                rx_src_short,
   input  wire logic                       rx_opt_ack,
   input  wire logic                       rx_opt_bcast,
   input  wire logic                       rx_opt_allpan,
   input  wire logic                       rx_opt_secure,
   input  wire logic                       rx_opt_apsenc,
   input  wire logic [1:0]                 rx_opt_method,
   input  wire logic [7:0]                 rx_len,
   // received payload stream
   input  wire logic                       pl_valid,
   input  wire logic [7:0]                 pl_data,
   output logic                            pl_ready,
   // transmit status request
   input  wire logic                       ts_valid,
   output logic                            ts_ready,
   input  wire logic [7:0]                 ts_frame_id,
   input  wire logic [15:0]                ts_dest_short,
   input  wire logic [7:0]                 ts_retries,
   input  wire apf_pkg::apf_delivery_type  ts_kind,
   input  wire logic [7:0]                 ts_discovery,
   // serial frame bytes
   output logic                            out_valid,
   output logic [7:0]                      out_data,
   input  wire logic                       out_ready
);

   // ****************************************************************
   // declarations
   // ****************************************************************
   apf_state_type state;
   apf_state_type next_state;
   logic [7:0]    fmt_opt;
   logic [1:0]    esc_mode;
   logic          enable;
   logic [31:0]   rx_count;
   logic [31:0]   ts_count;
   logic [31:0]   drop_count;
   logic          is_rx;
   logic [7:0]    hdr [0:11];
   logic [15:0]   frame_len;
   logic [3:0]    hdr_idx;
   logic [3:0]    hdr_last;
   logic [7:0]    pay_take;
   logic [7:0]    pay_emit;
   logic [7:0]    pay_len;
   logic [7:0]    hold;
   logic          hold_full;
   logic          next_hold_full;
   logic          take;
   logic [7:0]    sum;
   logic [7:0]    cur_byte;
   logic          emit;
   logic          buf_ready;
   logic          push;
   logic          rx_go;
   logic          ts_go;
   logic          rx_drop;
   logic [7:0]    status_code;
   logic [7:0]    rx_opts;

   // ****************************************************************
   // register port
   // ****************************************************************
   // escaping is not built: every mode leaves bytes as laid out
   always_ff @(posedge clk_sys) begin
      if (!rst_b) begin
         fmt_opt  <= `APF_RST_FMT;
         esc_mode <= `APF_RST_ESC;
         enable   <= `APF_RST_EN;
      end else if (reg_wr && reg_addr == `APF_REG_CTRL) begin
         fmt_opt  <= reg_wdata[`APF_CTRL_FMT_LSB +: 8];
         esc_mode <= reg_wdata[`APF_CTRL_ESC_LSB +: 2];
         enable   <= reg_wdata[`APF_CTRL_EN_BIT];
      end
   end

   always_ff @(posedge clk_sys) begin
      if (!rst_b) begin
         reg_rdata <= 32'h0000_0000;
      end else if (reg_rd) begin
         unique case (reg_addr)
            `APF_REG_CTRL: begin
               reg_rdata <= {15'h0000, enable, 6'h00, esc_mode, fmt_opt};
            end
            `APF_REG_STATUS: begin
               reg_rdata <= {16'h0000, 1'b0, state, hold_full, pl_ready, is_rx, 4'h0, ~state[0]};
            end
            `APF_REG_RX_COUNT:   reg_rdata <= rx_count;
            `APF_REG_TS_COUNT:   reg_rdata <= ts_count;
            `APF_REG_DROP_COUNT: reg_rdata <= drop_count;
            // arbitrary identification value
            `APF_REG_ID:         reg_rdata <= `APF_ID_VALUE;
            default:             reg_rdata <= 32'h0000_0000;
         endcase
      end else begin
         reg_rdata <= 32'h0000_0000;
      end
   end

   // ****************************************************************
   // request acceptance
   // ****************************************************************
   // status frames go first: the host is waiting on them to pace its own traffic
   assign ts_go   = ts_valid & ts_ready;
   assign rx_go   = rx_valid & rx_ready & ~ts_valid;
   assign rx_drop = rx_go & (fmt_opt != `APF_FMT_STANDARD);

   always_ff @(posedge clk_sys) begin
      if (!rst_b) begin
         rx_ready <= 1'b0;
         ts_ready <= 1'b0;
      end else begin
         rx_ready <= enable & (next_state == APF_IDLE) & ~ts_go & ~rx_go;
         ts_ready <= enable & (next_state == APF_IDLE) & ~ts_go & ~rx_go;
      end
   end

   always_ff @(posedge clk_sys) begin
      if (!rst_b) begin
         rx_count   <= 32'h0000_0000;
         ts_count   <= 32'h0000_0000;
         drop_count <= 32'h0000_0000;
      end else begin
         if (rx_go && !rx_drop) rx_count <= rx_count + 32'h0000_0001;
         if (ts_go) ts_count <= ts_count + 32'h0000_0001;
         if (rx_drop) drop_count <= drop_count + 32'h0000_0001;
      end
   end

   // ****************************************************************
   // header capture
   // ****************************************************************
   apf_status_encode u_status (
      .kind  (ts_kind),
      .code  (status_code),
      .legal ()
   );

   always_comb begin
      rx_opts                       = 8'h00;
      rx_opts[`APF_OPT_ACK]         = rx_opt_ack;
      rx_opts[`APF_OPT_BCAST]       = rx_opt_bcast;
      rx_opts[`APF_OPT_ALLPAN]      = rx_opt_allpan;
      rx_opts[`APF_OPT_SECURE]      = rx_opt_secure;
      rx_opts[`APF_OPT_APSENC]      = rx_opt_apsenc;
      rx_opts[`APF_OPT_METHOD_LO+:2] = rx_opt_method;
   end

   // bytes from offset 3 onward; the status frame uses the first seven
   always_ff @(posedge clk_sys) begin
      if (!rst_b) begin
         is_rx     <= 1'b0;
         frame_len <= 16'h0000;
         pay_len   <= 8'h00;
         hdr_last  <= 4'h0;
         for (int i = 0; i < 12; i++) hdr[i] <= 8'h00;
      end else if (ts_go) begin
         is_rx     <= 1'b0;
         frame_len <= `APF_TS_HDR_LEN;
         pay_len   <= 8'h00;
         hdr_last  <= 4'(`APF_TS_HDR_LEN - 16'h0001);
         hdr[0]    <= `APF_TYPE_TS;
         hdr[1]    <= ts_frame_id;
         hdr[2]    <= ts_dest_short[15:8];
         hdr[3]    <= ts_dest_short[7:0];
         hdr[4]    <= ts_retries;
         hdr[5]    <= status_code;
         hdr[6]    <= ts_discovery;
      end else if (rx_go && !rx_drop) begin
         is_rx     <= 1'b1;
         frame_len <= `APF_RX_HDR_LEN + {8'h00, rx_len};
         pay_len   <= rx_len;
         hdr_last  <= 4'(`APF_RX_HDR_LEN - 16'h0001);
         hdr[0]    <= `APF_TYPE_RX;
         for (int i = 0; i < 8; i++) begin
            hdr[1 + i] <= rx_src_long[63 - 8 * i -: 8];
         end
         hdr[9]    <= rx_src_short[15:8];
         hdr[10]   <= rx_src_short[7:0];
         hdr[11]   <= rx_opts;
      end
   end

   // ****************************************************************
   // frame sequencer
   // ****************************************************************
   assign emit = state[1] | state[2] | state[3] | state[4] | state[6] | (state[5] & hold_full);
   assign push = emit & buf_ready;

   always_comb begin
      next_state = state;
      unique case (state)
         APF_IDLE:   if (ts_go || (rx_go && !rx_drop)) next_state = APF_DELIM;
         APF_DELIM:  if (push) next_state = APF_LEN_HI;
         APF_LEN_HI: if (push) next_state = APF_LEN_LO;
         APF_LEN_LO: if (push) next_state = APF_HDR;
         APF_HDR: begin
            if (push && hdr_idx == hdr_last) begin
               next_state = (is_rx && pay_len != 8'h00) ? APF_PAYLOAD : APF_CSUM;
            end
         end
         APF_PAYLOAD: if (push && pay_emit == pay_len - 8'h01) next_state = APF_CSUM;
         APF_CSUM:   if (push) next_state = APF_IDLE;
         default:    next_state = APF_IDLE;
      endcase
   end

   always_ff @(posedge clk_sys) begin
      if (!rst_b) state <= APF_IDLE;
      else state <= next_state;
   end

   always_ff @(posedge clk_sys) begin
      if (!rst_b) begin
         hdr_idx  <= 4'h0;
         pay_emit <= 8'h00;
      end else if (state == APF_IDLE) begin
         hdr_idx  <= 4'h0;
         pay_emit <= 8'h00;
      end else if (push) begin
         if (state == APF_HDR) hdr_idx <= hdr_idx + 4'h1;
         if (state == APF_PAYLOAD) pay_emit <= pay_emit + 8'h01;
      end
   end

   // ****************************************************************
   // payload intake
   // ****************************************************************
   // a one-byte hold keeps pl_ready a flop; the price is one byte per two cycles
   assign take = pl_valid & pl_ready;

   always_comb begin
      next_hold_full = hold_full;
      if (state == APF_PAYLOAD && push) next_hold_full = 1'b0;
      if (take) next_hold_full = 1'b1;
   end

   always_ff @(posedge clk_sys) begin
      if (!rst_b) begin
         hold      <= 8'h00;
         hold_full <= 1'b0;
         pay_take  <= 8'h00;
         pl_ready  <= 1'b0;
      end else begin
         hold_full <= next_hold_full;
         if (take) hold <= pl_data;
         if (state == APF_IDLE) pay_take <= 8'h00;
         else if (take) pay_take <= pay_take + 8'h01;
         pl_ready  <= (next_state == APF_PAYLOAD) & ~next_hold_full & ~take &
                      (pay_take + {7'h00, take} < pay_len);
      end
   end

   // ****************************************************************
   // byte select and checksum
   // ****************************************************************
   always_comb begin
      cur_byte = 8'h00;
      unique case (state)
         APF_DELIM:   cur_byte = `APF_DELIM;
         APF_LEN_HI:  cur_byte = frame_len[15:8];
         APF_LEN_LO:  cur_byte = frame_len[7:0];
         APF_HDR:     cur_byte = hdr[hdr_idx];
         APF_PAYLOAD: cur_byte = hold;
         APF_CSUM:    cur_byte = `APF_CSUM_BASE - sum;
         default:     cur_byte = 8'h00;
      endcase
   end

   // the sum starts at the frame type byte, offset 3
   always_ff @(posedge clk_sys) begin
      if (!rst_b) sum <= 8'h00;
      else if (state == APF_IDLE) sum <= 8'h00;
      else if (push && (state == APF_HDR || state == APF_PAYLOAD)) sum <= sum + cur_byte;
   end

   // ****************************************************************
   // output buffer
   // ****************************************************************
   // bytes enter exactly as laid out; no stuffing in the path
   apf_pipe_buf u_buf (
      .clk_sys   (clk_sys),
      .rst_b     (rst_b),
      .in_valid  (emit),
      .in_data   (cur_byte),
      .in_ready  (buf_ready),
      .out_valid (out_valid),
      .out_data  (out_data),
      .out_ready (out_ready)
   );

endmodule : apf_framer

`default_nettype wire

// *** verilog/apf_map.svh ***
`ifndef APF_MAP_SVH
`define APF_MAP_SVH

// ****************************************************************
// frame layout
// ****************************************************************
`define APF_DELIM          8'h7e
`define APF_TYPE_RX        8'h90
`define APF_TYPE_TS        8'h8b
`define APF_RX_HDR_LEN     16'h000c
`define APF_TS_HDR_LEN     16'h0007
`define APF_CSUM_BASE      8'hff
`define APF_FMT_STANDARD   8'h00
`define APF_ESC_NONE       2'h1

// ****************************************************************
// receive options bit positions
// ****************************************************************
`define APF_OPT_ACK        0
`define APF_OPT_BCAST      1
`define APF_OPT_ALLPAN     2
`define APF_OPT_SECURE     4
`define APF_OPT_APSENC     5
`define APF_OPT_METHOD_LO  6

// ****************************************************************
// delivery status codes
// ****************************************************************
`define APF_DS_SUCCESS     8'h00
`define APF_DS_MAC_ACK     8'h01
`define APF_DS_CCA         8'h02
`define APF_DS_INDIRECT    8'h03
`define APF_DS_NET_ACK     8'h21
`define APF_DS_RESOURCE    8'h31
`define APF_DS_NO_SESSION  8'h34
`define APF_DS_ENCRYPT     8'h35
`define APF_DS_TOO_LARGE   8'h74

// ****************************************************************
// register map, fields and reset values
// ****************************************************************
`define APF_REG_CTRL       8'h00
`define APF_REG_STATUS     8'h04
`define APF_REG_RX_COUNT   8'h08
`define APF_REG_TS_COUNT   8'h0c
`define APF_REG_DROP_COUNT 8'h10
`define APF_REG_ID         8'h14
`define APF_CTRL_FMT_LSB   0
`define APF_CTRL_ESC_LSB   8
`define APF_CTRL_EN_BIT    16
`define APF_RST_FMT        8'h00
`define APF_RST_ESC        2'h1
`define APF_RST_EN         1'b1
`define APF_ID_VALUE       32'h00a5_0001

`endif

// *** verilog/apf_pipe_buf.sv ***
`timescale 1ns/10ps
`default_nettype none

module apf_pipe_buf (
   // clock and reset
   input  wire logic       clk_sys,
   input  wire logic       rst_b,
   // filling side
   input  wire logic       in_valid,
   input  wire logic [7:0] in_data,
   output logic            in_ready,
   // draining side
   output logic            out_valid,
   output logic [7:0]      out_data,
   input  wire logic       out_ready
);

   // ****************************************************************
   // two slots, head always in slot 0
   // ****************************************************************
   // in_ready is a flop so the framer never sees a path from the sink
   logic [7:0] slot1;
   logic       full1;
   logic       push;
   logic       pop;

   assign push = in_valid & in_ready;
   assign pop  = out_valid & out_ready;

   always_ff @(posedge clk_sys) begin
      if (!rst_b) begin
         out_valid <= 1'b0;
         full1     <= 1'b0;
         in_ready  <= 1'b1;
      end else begin
         unique case ({push, pop})
            2'b10: begin
               out_valid <= 1'b1;
               full1     <= out_valid;
               in_ready  <= ~out_valid;
            end
            2'b01: begin
               out_valid <= full1;
               full1     <= 1'b0;
               in_ready  <= 1'b1;
            end
            default: ;
         endcase
      end
   end

   always_ff @(posedge clk_sys) begin
      if (!rst_b) begin
         out_data <= 8'h00;
         slot1    <= 8'h00;
      end else begin
         if (push && !pop && out_valid) slot1 <= in_data;
         if (push && !pop && !out_valid) out_data <= in_data;
         if (pop) out_data <= full1 ? slot1 : in_data;
         if (push && pop && full1) slot1 <= in_data;
      end
   end

endmodule : apf_pipe_buf

`default_nettype wire

// *** verilog/apf_pkg.sv ***
`default_nettype none

package apf_pkg;

   // ****************************************************************
   // types
   // ****************************************************************
   typedef enum logic [6:0] {
      APF_IDLE    = 7'b000_0001,
      APF_DELIM   = 7'b000_0010,
      APF_LEN_HI  = 7'b000_0100,
      APF_LEN_LO  = 7'b000_1000,
      APF_HDR     = 7'b001_0000,
      APF_PAYLOAD = 7'b010_0000,
      APF_CSUM    = 7'b100_0000
   } apf_state_type;

   typedef enum logic [3:0] {
      APF_ST_SUCCESS, APF_ST_MAC_ACK, APF_ST_CCA, APF_ST_INDIRECT, APF_ST_NET_ACK,
      APF_ST_RESOURCE, APF_ST_NO_SESSION, APF_ST_ENCRYPT, APF_ST_TOO_LARGE
   } apf_delivery_type;

endpackage : apf_pkg

`default_nettype wire

// *** verilog/apf_status_encode.sv ***
`timescale 1ns/10ps
`default_nettype none
`include "apf_map.svh"

module apf_status_encode
   import apf_pkg::*;
(
   // outcome in
   input  wire apf_pkg::apf_delivery_type kind,
   // code out
   output logic [7:0]                     code,
   output logic                           legal
);

   // ****************************************************************
   // outcome to delivery status byte
   // ****************************************************************
   always_comb begin
      legal = 1'b1;
      unique case (kind)
         APF_ST_SUCCESS:    code = `APF_DS_SUCCESS;
         APF_ST_MAC_ACK:    code = `APF_DS_MAC_ACK;
         APF_ST_CCA:        code = `APF_DS_CCA;
         APF_ST_INDIRECT:   code = `APF_DS_INDIRECT;
         APF_ST_NET_ACK:    code = `APF_DS_NET_ACK;
         APF_ST_RESOURCE:   code = `APF_DS_RESOURCE;
         APF_ST_NO_SESSION: code = `APF_DS_NO_SESSION;
         APF_ST_ENCRYPT:    code = `APF_DS_ENCRYPT;
         APF_ST_TOO_LARGE:  code = `APF_DS_TOO_LARGE;
         // unused kind codes fall back to an internal resource error
         default: begin
            code  = `APF_DS_RESOURCE;
            legal = 1'b0;
         end
      endcase
   end

endmodule : apf_status_encode

`default_nettype wire
